/* verilog/apr_dev.sv */
`timescale 1ns/1ps
`include "apr_defs.svh"
module apr_dev #(
   parameter int MAX_BLK = 4
) (
   input  wire logic        core_clk,
   input  wire logic        srst,
   apr_link_if.dev          lnk,
   input  wire logic [7:0]  mult_cnt,
   input  wire logic        mult_en,
   output logic             med_req,
   output logic [47:0]      med_lba,
   input  wire logic        med_valid,
   input  wire logic [15:0] med_word,
   input  wire logic        med_last,
   input  wire logic        med_corr,
   input  wire logic        med_unc
);
   localparam int DEPTH = MAX_BLK << `APR_SECT_SHIFT;
   localparam int AW    = $clog2(DEPTH);

   function automatic logic [8:0] blk_len(input logic [16:0] rem, input logic [8:0] blk);
      blk_len = (rem < {8'h00, blk}) ? rem[8:0] : blk;
   endfunction

   apr_pkg::apr_dev_state_t st_q;
   logic [15:0] cnt_q;
   logic [15:0] sec_q;
   logic [15:0] clo_q;
   logic [15:0] chi_q;
   logic [7:0]  dh_q;
   logic        bsy_q;
   logic        drq_q;
   logic        err_q;
   logic        corr_q;
   logic [7:0]  erreg_q;
   logic        ext_q;
   logic        multi_q;
   logic [16:0] remain_q;
   logic [8:0]  blk_q;
   logic [8:0]  left_q;
   logic [47:0] cur_lba_q;
   logic [47:0] last_lba_q;
   logic [47:0] err_lba_q;
   logic        err_seen_q;
   logic        unc_q;
   logic        bcorr_q;
   logic [AW:0] wr_ptr_q;
   logic [AW:0] rd_ptr_q;
   logic [15:0] mem [0:DEPTH-1];

   logic        cmd_go;
   logic        is_rd;
   logic        is_multi;
   logic        is_ext;
   logic        start_ok;
   logic [16:0] cnt_tot;
   logic [47:0] start_lba;
   logic [8:0]  blk_sel;
   logic        sec_end;
   logic        xfer_go;
   logic        rd_take;
   logic        rd_last;
   logic        stop;
   logic [47:0] rep_lba;

   assign cmd_go   = lnk.tf_wr && (lnk.tf_addr == `APR_TF_CMD) && (st_q == apr_pkg::DV_IDLE);
   assign is_rd    = (lnk.tf_wdata == `APR_OP_RD) || (lnk.tf_wdata == `APR_OP_RD_LEG);
   assign is_ext   = (lnk.tf_wdata == `APR_OP_RDM_EXT);
   assign is_multi = (lnk.tf_wdata == `APR_OP_RDM) || is_ext;
   // A block count above the buffer size cannot be honoured, so it aborts like an unset one.
   assign start_ok = cmd_go && (is_rd || (is_multi && mult_en && (mult_cnt != 8'h00)
                     && ({24'h0, mult_cnt} <= MAX_BLK)));
   assign cnt_tot  = is_ext ? ((cnt_q == 16'h0000) ? `APR_MAX48 : {1'b0, cnt_q})
                   : ((cnt_q[7:0] == 8'h00) ? `APR_MAX28 : {9'h000, cnt_q[7:0]});
   assign start_lba = is_ext ? {chi_q[15:8], clo_q[15:8], sec_q[15:8],
                                chi_q[7:0], clo_q[7:0], sec_q[7:0]}
                    : {20'h00000, dh_q[3:0], chi_q[7:0], clo_q[7:0], sec_q[7:0]};
   assign blk_sel  = is_multi ? {1'b0, mult_cnt} : 9'h001;
   assign sec_end  = (st_q == apr_pkg::DV_FILL) && med_valid && med_last;
   assign xfer_go  = sec_end && (left_q == 9'h001);
   assign rd_take  = lnk.data_rd && (st_q == apr_pkg::DV_XFER);
   assign rd_last  = rd_take && (rd_ptr_q == wr_ptr_q - 1'b1);
   // Single reads stop on any error; multiple reads only on uncorrectable ones.
   assign stop     = (remain_q == 17'h00000) || unc_q || (!multi_q && err_seen_q);
   assign rep_lba  = err_seen_q ? err_lba_q : last_lba_q;

   always_ff @(posedge core_clk)
   begin
      if (srst)
         st_q <= apr_pkg::DV_IDLE;
      else
         unique case (st_q)
            apr_pkg::DV_IDLE: if (start_ok) st_q <= apr_pkg::DV_REQ;
            apr_pkg::DV_REQ:  st_q <= apr_pkg::DV_FILL;
            apr_pkg::DV_FILL:
               if (sec_end)
                  st_q <= xfer_go ? apr_pkg::DV_XFER : apr_pkg::DV_REQ;
            apr_pkg::DV_XFER:
               if (rd_last)
                  st_q <= stop ? apr_pkg::DV_DONE : apr_pkg::DV_REQ;
            apr_pkg::DV_DONE: st_q <= apr_pkg::DV_IDLE;
            default:          st_q <= apr_pkg::DV_IDLE;
         endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         ext_q      <= 1'b0;
         multi_q    <= 1'b0;
         blk_q      <= 9'h000;
         remain_q   <= 17'h00000;
         left_q     <= 9'h000;
         cur_lba_q  <= 48'h0;
         last_lba_q <= 48'h0;
      end
      else if (start_ok)
      begin
         ext_q     <= is_ext;
         multi_q   <= is_multi;
         blk_q     <= blk_sel;
         remain_q  <= cnt_tot;
         left_q    <= blk_len(cnt_tot, blk_sel);
         cur_lba_q <= start_lba;
      end
      else if (sec_end)
      begin
         remain_q   <= remain_q - 17'h00001;
         left_q     <= left_q - 9'h001;
         last_lba_q <= cur_lba_q;
         cur_lba_q  <= cur_lba_q + 48'h1;
      end
      else if (rd_last && !stop)
         left_q <= blk_len(remain_q, blk_q);
   end

   always_ff @(posedge core_clk)
   begin
      if (srst || start_ok)
      begin
         err_seen_q <= 1'b0;
         err_lba_q  <= 48'h0;
         unc_q      <= 1'b0;
         bcorr_q    <= 1'b0;
      end
      else if (sec_end)
      begin
         if ((med_corr || med_unc) && !err_seen_q)
         begin
            err_seen_q <= 1'b1;
            err_lba_q  <= cur_lba_q;
         end
         unc_q   <= unc_q || med_unc;
         bcorr_q <= bcorr_q || med_corr;
      end
      else if (rd_last)
         bcorr_q <= 1'b0;
   end

   always_ff @(posedge core_clk)
   begin
      if (srst || start_ok || rd_last)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
      end
      else
      begin
         if ((st_q == apr_pkg::DV_FILL) && med_valid)
            wr_ptr_q <= wr_ptr_q + 1'b1;
         if (rd_take)
            rd_ptr_q <= rd_ptr_q + 1'b1;
      end
   end

   // The buffer keeps its contents after a failure, so flawed data stays readable.
   always_ff @(posedge core_clk)
   begin
      if ((st_q == apr_pkg::DV_FILL) && med_valid)
         mem[wr_ptr_q[AW-1:0]] <= med_word;
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         bsy_q   <= 1'b0;
         drq_q   <= 1'b0;
         err_q   <= 1'b0;
         corr_q  <= 1'b0;
         erreg_q <= 8'h00;
      end
      else if (start_ok)
      begin
         bsy_q   <= 1'b1;
         drq_q   <= 1'b0;
         err_q   <= 1'b0;
         corr_q  <= 1'b0;
         erreg_q <= 8'h00;
      end
      else if (cmd_go)
      begin
         err_q                <= 1'b1;
         erreg_q[`APR_ER_ABRT] <= 1'b1;
      end
      else if (xfer_go)
      begin
         drq_q                <= 1'b1;
         bsy_q                <= 1'b0;
         err_q                <= unc_q || med_unc;
         corr_q               <= bcorr_q || med_corr;
         erreg_q[`APR_ER_UNC] <= unc_q || med_unc;
      end
      else if (rd_last)
      begin
         drq_q <= 1'b0;
         bsy_q <= !stop;
      end
   end

   // A new interrupt wins over the clear caused by a status read in the same cycle.
   always_ff @(posedge core_clk)
   begin
      if (srst)
         lnk.intrq <= 1'b0;
      else if (xfer_go || (cmd_go && !start_ok))
         lnk.intrq <= 1'b1;
      else if (start_ok || (lnk.tf_rd && (lnk.tf_addr == `APR_TF_CMD)))
         lnk.intrq <= 1'b0;
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         cnt_q <= 16'h0000;
         sec_q <= 16'h0000;
         clo_q <= 16'h0000;
         chi_q <= 16'h0000;
         dh_q  <= 8'h00;
      end
      else if (st_q == apr_pkg::DV_DONE)
      begin
         sec_q <= {rep_lba[31:24], rep_lba[7:0]};
         clo_q <= {rep_lba[39:32], rep_lba[15:8]};
         chi_q <= {rep_lba[47:40], rep_lba[23:16]};
         if (!ext_q)
            dh_q[3:0] <= rep_lba[27:24];
      end
      else if (lnk.tf_wr && (st_q == apr_pkg::DV_IDLE))
         unique case (lnk.tf_addr)
            `APR_TF_CNT: cnt_q <= {cnt_q[7:0], lnk.tf_wdata};
            `APR_TF_SEC: sec_q <= {sec_q[7:0], lnk.tf_wdata};
            `APR_TF_CLO: clo_q <= {clo_q[7:0], lnk.tf_wdata};
            `APR_TF_CHI: chi_q <= {chi_q[7:0], lnk.tf_wdata};
            `APR_TF_DH:  dh_q  <= lnk.tf_wdata;
            default:     dh_q  <= dh_q;
         endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (srst || !lnk.tf_rd)
         lnk.tf_rdata <= 8'h00;
      else
         unique case (lnk.tf_addr)
            `APR_TF_ERR: lnk.tf_rdata <= erreg_q;
            `APR_TF_CNT: lnk.tf_rdata <= cnt_q[7:0];
            `APR_TF_SEC: lnk.tf_rdata <= sec_q[7:0];
            `APR_TF_CLO: lnk.tf_rdata <= clo_q[7:0];
            `APR_TF_CHI: lnk.tf_rdata <= chi_q[7:0];
            `APR_TF_DH:  lnk.tf_rdata <= dh_q;
            `APR_TF_CMD: lnk.tf_rdata <= {bsy_q, 1'b1, 1'b0, 1'b1, drq_q, corr_q, 1'b0, err_q};
            default:     lnk.tf_rdata <= 8'h00;
         endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         lnk.data_rdata <= 16'h0000;
         med_req        <= 1'b0;
         med_lba        <= 48'h0;
      end
      else
      begin
         lnk.data_rdata <= rd_take ? mem[rd_ptr_q[AW-1:0]] : 16'h0000;
         med_req        <= (st_q == apr_pkg::DV_REQ);
         med_lba        <= cur_lba_q;
      end
   end
endmodule

/* inc/apr_defs.svh */
`ifndef APR_DEFS_SVH
`define APR_DEFS_SVH
// Task-file register addresses on the link.
`define APR_TF_ERR      3'h1
`define APR_TF_CNT      3'h2
`define APR_TF_SEC      3'h3
`define APR_TF_CLO      3'h4
`define APR_TF_CHI      3'h5
`define APR_TF_DH       3'h6
`define APR_TF_CMD      3'h7
// Command codes.
`define APR_OP_RD       8'h20
`define APR_OP_RD_LEG   8'h21
`define APR_OP_RDM      8'hC4
`define APR_OP_RDM_EXT  8'h29
// Status and error bit positions.
`define APR_ST_BSY      7
`define APR_ST_DRDY     6
`define APR_ST_DSC      4
`define APR_ST_DRQ      3
`define APR_ST_CORR     2
`define APR_ST_ERR      0
`define APR_ER_UNC      6
`define APR_ER_ABRT     2
// Sector geometry, count limits and the LBA-mode device/head value.
`define APR_SECT_SHIFT  8
`define APR_MAX28       17'h00100
`define APR_MAX48       17'h10000
`define APR_DH_LBA      8'hE0
// Host command-port register offsets and the last setup step.
`define APR_H_OPC       3'h0
`define APR_H_LBALO     3'h1
`define APR_H_LBAHI     3'h2
`define APR_H_CNT       3'h3
`define APR_H_BLK       3'h4
`define APR_H_GO        3'h5
`define APR_H_LAST_STEP 4'h9
`endif

/* inc/apr_pkg.sv */
package apr_pkg;
   typedef enum logic [2:0]
   {
      DV_IDLE = 3'h0,
      DV_REQ  = 3'h1,
      DV_FILL = 3'h3,
      DV_XFER = 3'h2,
      DV_DONE = 3'h6
   } apr_dev_state_t;
   typedef enum logic [2:0]
   {
      HS_IDLE  = 3'h0,
      HS_SETUP = 3'h1,
      HS_WAIT  = 3'h3,
      HS_STAT  = 3'h2,
      HS_DATA  = 3'h6,
      HS_CHK   = 3'h7,
      HS_EVAL  = 3'h5
   } apr_host_state_t;
endpackage

/* inc/apr_link_if.sv */
`timescale 1ns/1ps
interface apr_link_if;
   logic        tf_wr;
   logic        tf_rd;
   logic [2:0]  tf_addr;
   logic [7:0]  tf_wdata;
   logic [7:0]  tf_rdata;
   logic        data_rd;
   logic [15:0] data_rdata;
   logic        intrq;
   modport dev  (input tf_wr, tf_rd, tf_addr, tf_wdata, data_rd,
                 output tf_rdata, data_rdata, intrq);
   modport host (output tf_wr, tf_rd, tf_addr, tf_wdata, data_rd,
                 input tf_rdata, data_rdata, intrq);
endinterface

/* verilog/apr_host.sv */
`timescale 1ns/1ps
`include "apr_defs.svh"
module apr_host (
   input  wire logic        core_clk,
   input  wire logic        srst,
   apr_link_if.host         lnk,
   input  wire logic [2:0]  cmd_addr,
   input  wire logic [31:0] cmd_wdata,
   input  wire logic        cmd_wr,
   input  wire logic        cmd_rd,
   output logic [31:0]      cmd_rdata,
   output logic             word_valid,
   output logic [15:0]      word_data
);
   apr_pkg::apr_host_state_t st_q;
   logic [7:0]  opc_q;
   logic [47:0] lba_q;
   logic [15:0] cnt_q;
   logic [7:0]  blk_q;
   logic [3:0]  step_q;
   logic [16:0] remain_q;
   logic [16:0] words_q;
   logic        done_q;
   logic        err_q;
   logic [7:0]  dstat_q;
   logic        rd_pend_q;
   logic        stat_pend_q;
   logic        is_ext;
   logic        go;
   logic [16:0] tot;
   logic [16:0] nsec;

   assign is_ext = (opc_q == `APR_OP_RDM_EXT);
   assign go     = cmd_wr && (cmd_addr == `APR_H_GO) && (st_q == apr_pkg::HS_IDLE);
   assign tot    = is_ext ? ((cnt_q == 16'h0000) ? `APR_MAX48 : {1'b0, cnt_q})
                 : ((cnt_q[7:0] == 8'h00) ? `APR_MAX28 : {9'h000, cnt_q[7:0]});
   // Single reads move one sector per data request; multiple reads a block, or the sectors left if fewer.
   assign nsec   = ((opc_q == `APR_OP_RDM) || is_ext) && (remain_q > {9'h000, blk_q})
                 ? {9'h000, blk_q} : (((opc_q == `APR_OP_RDM) || is_ext) ? remain_q : 17'h00001);

   // Upper bytes go first so the device keeps them as the previous write.
   function automatic logic [10:0] step_wr(input logic [3:0] s);
      unique case (s)
         4'h0:    step_wr = {`APR_TF_CNT, cnt_q[15:8]};
         4'h1:    step_wr = {`APR_TF_CNT, cnt_q[7:0]};
         4'h2:    step_wr = {`APR_TF_SEC, lba_q[31:24]};
         4'h3:    step_wr = {`APR_TF_SEC, lba_q[7:0]};
         4'h4:    step_wr = {`APR_TF_CLO, lba_q[39:32]};
         4'h5:    step_wr = {`APR_TF_CLO, lba_q[15:8]};
         4'h6:    step_wr = {`APR_TF_CHI, lba_q[47:40]};
         4'h7:    step_wr = {`APR_TF_CHI, lba_q[23:16]};
         4'h8:    step_wr = {`APR_TF_DH, `APR_DH_LBA | (is_ext ? 8'h00 : {4'h0, lba_q[27:24]})};
         default: step_wr = {`APR_TF_CMD, opc_q};
      endcase
   endfunction

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         opc_q <= 8'h00;
         lba_q <= 48'h0;
         cnt_q <= 16'h0000;
         blk_q <= 8'h01;
      end
      else if (cmd_wr && (st_q == apr_pkg::HS_IDLE))
         unique case (cmd_addr)
            `APR_H_OPC:   opc_q         <= cmd_wdata[7:0];
            `APR_H_LBALO: lba_q[31:0]   <= cmd_wdata;
            `APR_H_LBAHI: lba_q[47:32]  <= cmd_wdata[15:0];
            `APR_H_CNT:   cnt_q         <= cmd_wdata[15:0];
            `APR_H_BLK:   blk_q         <= cmd_wdata[7:0];
            default:      blk_q         <= blk_q;
         endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         st_q     <= apr_pkg::HS_IDLE;
         step_q   <= 4'h0;
         remain_q <= 17'h00000;
         words_q  <= 17'h00000;
         done_q   <= 1'b0;
         err_q    <= 1'b0;
         dstat_q  <= 8'h00;
      end
      else
         unique case (st_q)
            apr_pkg::HS_IDLE:
               if (go)
               begin
                  st_q     <= apr_pkg::HS_SETUP;
                  step_q   <= 4'h0;
                  remain_q <= tot;
                  done_q   <= 1'b0;
                  err_q    <= 1'b0;
               end
            apr_pkg::HS_SETUP:
            begin
               step_q <= step_q + 4'h1;
               if (step_q == `APR_H_LAST_STEP)
                  st_q <= apr_pkg::HS_WAIT;
            end
            apr_pkg::HS_WAIT:
               if (lnk.intrq)
                  st_q <= apr_pkg::HS_STAT;
            apr_pkg::HS_STAT:
               // The status answer stands only in the cycle after the registered strobe.
               if (stat_pend_q)
               begin
                  dstat_q <= lnk.tf_rdata;
                  err_q   <= err_q || lnk.tf_rdata[`APR_ST_ERR];
                  if (lnk.tf_rdata[`APR_ST_DRQ])
                  begin
                     remain_q <= remain_q - nsec;
                     words_q  <= nsec << `APR_SECT_SHIFT;
                     st_q     <= apr_pkg::HS_DATA;
                  end
                  else
                  begin
                     done_q <= 1'b1;
                     st_q   <= apr_pkg::HS_IDLE;
                  end
               end
            apr_pkg::HS_DATA:
            begin
               words_q <= words_q - 17'h00001;
               if (words_q == 17'h00001)
               begin
                  done_q <= (remain_q == 17'h00000);
                  st_q   <= (remain_q == 17'h00000) ? apr_pkg::HS_IDLE : apr_pkg::HS_CHK;
               end
            end
            apr_pkg::HS_CHK:  st_q <= apr_pkg::HS_EVAL;
            apr_pkg::HS_EVAL:
               if (stat_pend_q)
               begin
                  dstat_q <= lnk.tf_rdata;
                  // A device that is no longer busy has ended the command early, whatever its request bit.
                  if (lnk.tf_rdata[`APR_ST_BSY])
                     st_q <= apr_pkg::HS_WAIT;
                  else
                  begin
                     done_q <= 1'b1;
                     err_q  <= 1'b1;
                     st_q   <= apr_pkg::HS_IDLE;
                  end
               end
            default: st_q <= apr_pkg::HS_IDLE;
         endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         lnk.tf_wr    <= 1'b0;
         lnk.tf_rd    <= 1'b0;
         lnk.tf_addr  <= 3'h0;
         lnk.tf_wdata <= 8'h00;
         lnk.data_rd  <= 1'b0;
      end
      else
      begin
         lnk.tf_wr   <= (st_q == apr_pkg::HS_SETUP);
         lnk.tf_rd   <= ((st_q == apr_pkg::HS_WAIT) && lnk.intrq) || (st_q == apr_pkg::HS_CHK);
         lnk.data_rd <= (st_q == apr_pkg::HS_DATA);
         if (st_q == apr_pkg::HS_SETUP)
            {lnk.tf_addr, lnk.tf_wdata} <= step_wr(step_q);
         else
         begin
            lnk.tf_addr  <= `APR_TF_CMD;
            lnk.tf_wdata <= 8'h00;
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         rd_pend_q  <= 1'b0;
         stat_pend_q <= 1'b0;
         word_valid <= 1'b0;
         word_data  <= 16'h0000;
         cmd_rdata  <= 32'h0;
      end
      else
      begin
         rd_pend_q  <= lnk.data_rd;
         stat_pend_q <= lnk.tf_rd;
         word_valid <= rd_pend_q;
         word_data  <= rd_pend_q ? lnk.data_rdata : 16'h0000;
         if (!cmd_rd)
            cmd_rdata <= 32'h0;
         else
            unique case (cmd_addr)
               `APR_H_OPC:   cmd_rdata <= {24'h0, opc_q};
               `APR_H_LBALO: cmd_rdata <= lba_q[31:0];
               `APR_H_LBAHI: cmd_rdata <= {16'h0, lba_q[47:32]};
               `APR_H_CNT:   cmd_rdata <= {16'h0, cnt_q};
               `APR_H_BLK:   cmd_rdata <= {24'h0, blk_q};
               `APR_H_GO:    cmd_rdata <= {21'h0, dstat_q, err_q, done_q,
                                           st_q != apr_pkg::HS_IDLE};
               default:      cmd_rdata <= 32'h0;
            endcase
      end
   end
endmodule

/* sim/apr_link_asserts.sv */
`timescale 1ns/1ps
module apr_link_asserts (
   input wire logic        core_clk,
   input wire logic        srst,
   input wire logic        tf_wr,
   input wire logic        tf_rd,
   input wire logic [2:0]  tf_addr,
   input wire logic [7:0]  tf_wdata,
   input wire logic [7:0]  tf_rdata,
   input wire logic        data_rd,
   input wire logic [15:0] data_rdata,
   input wire logic        intrq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   logic [7:0] wcnt_q;
   logic       st_rd;
   assign st_rd = tf_rd && tf_addr == 3'h7;
   // Words since the last status read; only whole sectors may lie between interrupts.
   always_ff @(posedge core_clk)
   begin
      if (srst || st_rd)
         wcnt_q <= 8'h00;
      else if (data_rd)
         wcnt_q <= wcnt_q + 8'h01;
   end
   property p_cmd_order;
      tf_wr && tf_addr == 3'h7 |-> $past(tf_wr && tf_addr == 3'h6);
   endproperty
   a_cmd_order: assert property (p_cmd_order) else $error("command early");
   property p_cnt_twice;
      tf_wr && tf_addr == 3'h2 && !$past(tf_wr) |=> tf_wr && tf_addr == 3'h2;
   endproperty
   a_cnt_twice: assert property (p_cnt_twice) else $error("count once");
   property p_blk_words;
      $rose(intrq) |-> wcnt_q == 8'h00;
   endproperty
   a_blk_words: assert property (p_blk_words) else $error("partial sector");
   property p_irq_read;
      $rose(intrq) |-> ##[1:20] st_rd;
   endproperty
   a_irq_read: assert property (p_irq_read) else $error("status unread");
   property p_irq_clear;
      st_rd |=> !intrq;
   endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("irq stuck");
   property p_quiet;
      data_rd |-> !intrq;
   endproperty
   a_quiet: assert property (p_quiet) else $error("irq in block");
   property p_stat;
      st_rd && intrq |=> tf_rdata[7:4] == 4'h5 && (tf_rdata[3] || tf_rdata[0]);
   endproperty
   a_stat: assert property (p_stat) else $error("bad status");
   property p_data_idle;
      !$past(data_rd) |-> data_rdata == 16'h0000;
   endproperty
   a_data_idle: assert property (p_data_idle) else $error("stray data");
   c_irq: cover property ($rose(intrq));
   c_ext: cover property (tf_wr && tf_addr == 3'h7 && tf_wdata == 8'h29);
   c_err: cover property (st_rd && intrq ##1 tf_rdata[0]);
endmodule

/* sim/ata_pio_sector_read_engine_tb_top.sv */
`timescale 1ns/1ps
module ata_pio_sector_read_engine_tb_top;
   logic        core_clk, srst, cmd_wr, cmd_rd, word_valid, med_req, med_valid;
   logic        med_last, med_corr, med_unc, mult_en, bad_unc, seen_q;
   logic [2:0]  cmd_addr;
   logic [7:0]  mult_cnt;
   logic [15:0] word_data, med_word;
   logic [31:0] cmd_wdata, cmd_rdata, rd_q;
   logic [47:0] med_lba, lba_q, lba0, bad_lba;
   int          fail_count, n_compared, words, irqs, midx;
   apr_link_if lnk();
   apr_dev #(.MAX_BLK(4)) apr_dev_inst (.core_clk, .srst, .lnk, .mult_cnt, .mult_en,
      .med_req, .med_lba, .med_valid, .med_word, .med_last, .med_corr, .med_unc);
   apr_host apr_host_inst (.core_clk, .srst, .lnk, .cmd_addr, .cmd_wdata, .cmd_wr,
      .cmd_rd, .cmd_rdata, .word_valid, .word_data);
   apr_link_asserts apr_link_asserts_inst (.core_clk, .srst, .tf_wr(lnk.tf_wr),
      .tf_rd(lnk.tf_rd), .tf_addr(lnk.tf_addr), .tf_wdata(lnk.tf_wdata),
      .tf_rdata(lnk.tf_rdata), .data_rd(lnk.data_rd), .data_rdata(lnk.data_rdata),
      .intrq(lnk.intrq));
   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // Media answers each request with 256 words; the error flags ride on the last one.
   always @(posedge core_clk)
   begin
      med_valid <= 1'b0;
      med_last <= 1'b0;
      if (med_req)
      begin
         lba_q <= med_lba;
         midx <= 1;
         if (!seen_q)
            lba0 <= med_lba;
         seen_q <= 1'b1;
      end
      else if (midx > 0)
      begin
         med_valid <= 1'b1;
         med_word <= {lba_q[7:0], 8'(midx - 1)};
         med_last <= midx == 256;
         med_corr <= midx == 256 && lba_q == bad_lba && !bad_unc;
         med_unc <= midx == 256 && lba_q == bad_lba && bad_unc;
         midx <= midx == 256 ? 0 : midx + 1;
      end
   end
   always @(posedge core_clk)
   begin
      if ($rose(lnk.intrq))
         irqs++;
      if (word_valid)
      begin
         check(48'(word_data), 48'({8'(lba0 + 48'(words / 256)), 8'(words)}));
         words++;
      end
   end
   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [31:0] d);
      cmd_addr <= a;
      cmd_wdata <= d;
      cmd_wr <= 1'b1;
      @(posedge core_clk);
      cmd_wr <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [2:0] a);
      cmd_addr <= a;
      cmd_rd <= 1'b1;
      @(posedge core_clk);
      cmd_rd <= 1'b0;
      @(posedge core_clk);
      rd_q = cmd_rdata;
   endtask
   task automatic run(input logic [7:0] op, input logic [47:0] lba, input logic [15:0] cnt,
                      input logic [7:0] blk, input logic [7:0] mc);
      words = 0;
      irqs = 0;
      seen_q = 1'b0;
      mult_cnt <= mc;
      wr(3'h0, 32'(op));
      wr(3'h1, lba[31:0]);
      wr(3'h2, 32'(lba[47:32]));
      wr(3'h3, 32'(cnt));
      wr(3'h4, 32'(blk));
      wr(3'h5, 32'h0000_0000);
      for (int t = 0; t < 5000; t++)
      begin
         rd(3'h5);
         if (rd_q[0] === 1'b0)
            break;
      end
      // The last word lands two cycles after busy drops.
      repeat (4) @(posedge core_clk);
      if (seen_q === 1'b1)
         check(lba0, lba);
   endtask
   task automatic ends(input int w, input int n, input logic e);
      check(48'(words), 48'(w));
      check(48'(irqs), 48'(n));
      check(48'(rd_q[2]), 48'(e));
      check(48'(rd_q[1]), 48'h1);
   endtask
   // The address bytes that the device leaves in its task file, put together as one address.
   task automatic tf_lba(input logic [47:0] exp);
      check({apr_dev_inst.chi_q[15:8], apr_dev_inst.clo_q[15:8], apr_dev_inst.sec_q[15:8],
             apr_dev_inst.chi_q[7:0], apr_dev_inst.clo_q[7:0], apr_dev_inst.sec_q[7:0]},
            exp);
   endtask
   task automatic t_single();
      run(8'h20, 48'h0000_0012_3456, 16'h0002, 8'h01, 8'h01);
      ends(512, 2, 1'b0);
      run(8'h21, 48'h0000_0000_0010, 16'h0001, 8'h01, 8'h01);
      ends(256, 1, 1'b0);
   endtask
   task automatic t_partial();
      run(8'hC4, 48'h0000_0000_0200, 16'h0005, 8'h02, 8'h02);
      ends(1280, 3, 1'b0);
      run(8'hC4, 48'h0000_0000_0300, 16'h0003, 8'h01, 8'h01);
      ends(768, 3, 1'b0);
   endtask
   task automatic t_ext();
      run(8'h29, 48'h1234_5678_9A00, 16'h0003, 8'h04, 8'h04);
      ends(768, 1, 1'b0);
      tf_lba(48'h1234_5678_9A02);
   endtask
   task automatic t_abort();
      run(8'hC4, 48'h0000_0000_0400, 16'h0002, 8'h01, 8'h00);
      ends(0, 1, 1'b1);
      mult_en <= 1'b0;
      run(8'hC4, 48'h0000_0000_0400, 16'h0002, 8'h01, 8'h01);
      ends(0, 1, 1'b1);
      mult_en <= 1'b1;
      run(8'h24, 48'h0000_0000_0400, 16'h0001, 8'h01, 8'h01);
      ends(0, 1, 1'b1);
   endtask
   task automatic t_errors();
      bad_lba = 48'h0000_0000_0041;
      bad_unc = 1'b1;
      run(8'hC4, 48'h0000_0000_0040, 16'h0004, 8'h02, 8'h02);
      ends(512, 1, 1'b1);
      tf_lba(48'h0000_0000_0041);
      bad_unc = 1'b0;
      run(8'hC4, 48'h0000_0000_0040, 16'h0004, 8'h02, 8'h02);
      ends(1024, 2, 1'b0);
      bad_unc = 1'b1;
      run(8'h20, 48'h0000_0000_0040, 16'h0003, 8'h01, 8'h01);
      ends(512, 2, 1'b1);
      tf_lba(48'h0000_0000_0041);
      bad_lba = 48'h1234_5678_9A01;
      run(8'h29, 48'h1234_5678_9A00, 16'h0003, 8'h04, 8'h04);
      ends(768, 1, 1'b1);
      tf_lba(48'h1234_5678_9A01);
   endtask
   task automatic conclude();
      if (fail_count == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      #2000000;
      fail_count++;
      conclude();
   end
   initial
   begin
      {cmd_wr, cmd_rd, med_valid, med_last, med_corr, med_unc, bad_unc, seen_q} = '0;
      {cmd_addr, cmd_wdata, mult_cnt, med_word} = '0;
      mult_en = 1'b1;
      bad_lba = '1;
      srst = 1'b1;
      repeat (10) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      t_single();
      t_partial();
      t_ext();
      t_abort();
      t_errors();
      conclude();
   end
endmodule
